// *** src/smrts_pkg.sv ***
// Purpose: constants for the supply monitor, reset and trim scheduler
// Assumes: 125 MHz mclk_in; 1 Hz time-base tick comes in as a pulse
// Notes:   long counts are also top-level parameters for simulation
package smrts_pkg;

    // ========================================================
    // clock and times
    // ========================================================
    localparam int unsigned CLK_KHZ          = 125000;
    localparam int unsigned RECOVERY_MS      = 250;
    localparam int unsigned DEBOUNCE_MS      = 30;
    localparam int unsigned RECOVERY_CYCLES  = RECOVERY_MS * CLK_KHZ;
    localparam int unsigned DEBOUNCE_CYCLES  = DEBOUNCE_MS * CLK_KHZ;
    localparam int unsigned CNT_W            = 25;

    // ========================================================
    // backup-supply rate divider
    // ========================================================
    localparam int unsigned BACKUP_DIV_W     = 4;
    localparam logic [3:0]  BACKUP_DIV_LAST  = 4'h9;

    // ========================================================
    // synchroniser bit positions
    // ========================================================
    localparam int unsigned SYNC_W           = 4;
    localparam int unsigned SYNC_VCC_OK      = 0;
    localparam int unsigned SYNC_ABOVE_BAT   = 1;
    localparam int unsigned SYNC_OSC_RUN     = 2;
    localparam int unsigned SYNC_RST_PIN     = 3;

    // ========================================================
    // adjustment arithmetic
    // ========================================================
    localparam int unsigned TEMP_W           = 10;
    localparam int unsigned TRIM_W           = 8;
    localparam int unsigned ADJ_W            = 11;
    localparam logic [10:0] TEMP_REF         = 11'h064;

    // ========================================================
    // reset line sequencer states
    // ========================================================
    typedef enum logic [5:0] {
        ST_PFAIL    = 6'h01,
        ST_RECOV    = 6'h02,
        ST_IDLE     = 6'h04,
        ST_DEBOUNCE = 6'h08,
        ST_WAIT_REL = 6'h10,
        ST_RSTHOLD  = 6'h20
    } smrts_state_t;

endpackage : smrts_pkg

// *** src/smrts_sync.sv ***
// Purpose: two-flop synchroniser for a bundle of level inputs
// Assumes: single clock, synchronous active-high reset
// Notes:   first stage is read only by the second stage
module smrts_sync #(
    parameter int unsigned W = 1
) (
    // clock and reset
    input  wire logic         mclk_in,
    input  wire logic         rst_in,
    // levels
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] meta_reg;
    logic [W-1:0] sync_reg;

    // ========================================================
    // one synchroniser per bit
    // ========================================================
    genvar i;
    generate
        for (i = 0; i < W; i++)
        begin : g_bit
            always_ff @(posedge mclk_in)
            begin
                if (rst_in)
                begin
                    meta_reg[i] <= 1'b0;
                    sync_reg[i] <= 1'b0;
                end
                else
                begin
                    meta_reg[i] <= async_in[i];
                    sync_reg[i] <= meta_reg[i];
                end
            end
        end
    endgenerate

    assign sync_out = sync_reg;

endmodule : smrts_sync

// *** src/smrts_top.sv ***
// Purpose: supply selection, open-drain reset sequencing, trim schedule
// Assumes: comparator levels and reset pin are asynchronous; synchronised here
// Notes:   reset pin is open drain; oe_n low means pulling it low
//
// Functional notes
// - main below threshold drives reset low
// - hold reset for recovery, then release line
// - recovery hold lasts about 250 ms
// - oscillator stopped: skip recovery, release at once
// - debounced pushbutton shares the reset pin
// - falling edge: debounce, await release, hold reset
// - on backup alone, reset output disabled
// - backup only when main below both references
// - correct time base from temperature result
// - main supply: adjust every second
// - backup supply: adjust every ten seconds
// - main supply: convert temperature every second
// - backup supply: convert every ten seconds
// - add signed aging offset to factory trim
// - reset and pushbutton only with main supply
module smrts_top #(
    parameter int unsigned RECOVERY_CYC = smrts_pkg::RECOVERY_CYCLES,
    parameter int unsigned DEBOUNCE_CYC = smrts_pkg::DEBOUNCE_CYCLES
) (
    // clock and reset
    input  wire logic                                mclk_in,
    input  wire logic                                rst_in,
    // supply comparators and oscillator status
    input  wire logic                                vcc_above_pf_in,
    input  wire logic                                vcc_above_bat_in,
    input  wire logic                                osc_running_in,
    // open-drain reset pin
    input  wire logic                                rst_pin_in,
    output logic                                     rst_pin_out,
    output logic                                     rst_pin_oe_n_out,
    // time base and temperature sensor
    input  wire logic                                tick_1hz_in,
    input  wire logic                                conv_done_in,
    input  wire logic signed [smrts_pkg::TEMP_W-1:0] temp_in,
    input  wire logic signed [smrts_pkg::TRIM_W-1:0] factory_trim_in,
    input  wire logic signed [smrts_pkg::TRIM_W-1:0] aging_offset_in,
    // status and schedule
    output logic                                     on_backup_out,
    output logic                                     conv_start_out,
    output logic                                     adj_strobe_out,
    output logic signed [smrts_pkg::ADJ_W-1:0]       adj_value_out
);
    import smrts_pkg::*;

    localparam logic [CNT_W-1:0] REC_LAST = CNT_W'(RECOVERY_CYC - 1);
    localparam logic [CNT_W-1:0] DB_LAST  = CNT_W'(DEBOUNCE_CYC - 1);

    // ========================================================
    // input synchronisers
    // ========================================================
    logic [SYNC_W-1:0] sync_w;
    logic              vcc_ok_s;
    logic              above_bat_s;
    logic              osc_s;
    logic              pin_s;

    // bat and pin bits stored inverted: reset value reads as idle
    smrts_sync #(
        .W        (SYNC_W)
    ) u_sync (
        .mclk_in  (mclk_in),
        .rst_in   (rst_in),
        .async_in ({!rst_pin_in, osc_running_in,
                    !vcc_above_bat_in, vcc_above_pf_in}),
        .sync_out (sync_w)
    );

    assign vcc_ok_s    = sync_w[SYNC_VCC_OK];
    assign above_bat_s = !sync_w[SYNC_ABOVE_BAT];
    assign osc_s       = sync_w[SYNC_OSC_RUN];
    assign pin_s       = !sync_w[SYNC_RST_PIN];

    // ========================================================
    // power source selection
    // ========================================================
    logic on_backup_reg;
    logic on_backup_next;
    logic pin_prev_reg;
    logic pin_prev_next;

    always_comb
    begin
        on_backup_next = !(vcc_ok_s || above_bat_s);
        pin_prev_next  = pin_s;
    end

    always_ff @(posedge mclk_in)
    begin
        if (rst_in)
        begin
            on_backup_reg <= 1'b0;
            pin_prev_reg  <= 1'b1;
        end
        else
        begin
            on_backup_reg <= on_backup_next;
            pin_prev_reg  <= pin_prev_next;
        end
    end

    // ========================================================
    // reset line sequencer
    // ========================================================
    smrts_state_t     state_reg;
    smrts_state_t     state_next;
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;
    logic             pin_fall;
    logic             pin_rise;
    logic             drive_low;

    assign pin_fall = pin_prev_reg && !pin_s;
    assign pin_rise = !pin_prev_reg && pin_s;

    always_comb
    begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        if (!vcc_ok_s)
        begin
            state_next = ST_PFAIL;
            cnt_next   = '0;
        end
        else
        begin
            case (state_reg)
                ST_PFAIL:
                begin
                    cnt_next   = '0;
                    state_next = osc_s ? ST_RECOV : ST_IDLE;
                end
                ST_RECOV, ST_RSTHOLD:
                begin
                    if (cnt_reg == REC_LAST)
                    begin
                        state_next = ST_IDLE;
                        cnt_next   = '0;
                    end
                    else
                    begin
                        cnt_next = cnt_reg + 1'b1;
                    end
                end
                ST_IDLE:
                begin
                    if (pin_fall)
                    begin
                        state_next = ST_DEBOUNCE;
                        cnt_next   = '0;
                    end
                end
                ST_DEBOUNCE:
                begin
                    if (cnt_reg == DB_LAST)
                    begin
                        state_next = ST_WAIT_REL;
                        cnt_next   = '0;
                    end
                    else
                    begin
                        cnt_next = cnt_reg + 1'b1;
                    end
                end
                ST_WAIT_REL:
                begin
                    if (pin_rise || pin_s)
                    begin
                        state_next = ST_RSTHOLD;
                        cnt_next   = '0;
                    end
                end
                default:
                begin
                    state_next = ST_PFAIL;
                    cnt_next   = '0;
                end
            endcase
        end
    end

    always_ff @(posedge mclk_in)
    begin
        if (rst_in)
        begin
            state_reg <= ST_PFAIL;
            cnt_reg   <= '0;
        end
        else
        begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
        end
    end

    // pulls low in fail, recovery, debounce and hold; never on backup
    assign drive_low = (state_reg != ST_IDLE) &&
                       (state_reg != ST_WAIT_REL) &&
                       !on_backup_reg;
    assign rst_pin_out      = 1'b0;
    assign rst_pin_oe_n_out = !drive_low;
    assign on_backup_out    = on_backup_reg;

    // ========================================================
    // conversion and adjustment schedule
    // ========================================================
    logic [BACKUP_DIV_W-1:0] div_reg;
    logic [BACKUP_DIV_W-1:0] div_next;
    logic                    busy_reg;
    logic                    busy_next;
    logic                    conv_reg;
    logic                    conv_next;
    logic                    adj_reg;
    logic                    adj_next;
    logic signed [ADJ_W-1:0] val_reg;
    logic signed [ADJ_W-1:0] val_next;
    logic signed [ADJ_W-1:0] temp_dev;
    logic signed [ADJ_W-1:0] adj_sum;
    logic                    fire;

    always_comb
    begin
        temp_dev = $signed({temp_in[TEMP_W-1], temp_in}) -
                   $signed(TEMP_REF);
        adj_sum  = -(temp_dev >>> 2) +
                   $signed({{3{factory_trim_in[TRIM_W-1]}},
                            factory_trim_in}) +
                   $signed({{3{aging_offset_in[TRIM_W-1]}},
                            aging_offset_in});
        fire     = tick_1hz_in &&
                   (!on_backup_reg || div_reg == BACKUP_DIV_LAST);
        div_next = div_reg;
        if (tick_1hz_in)
        begin
            if (on_backup_reg && div_reg != BACKUP_DIV_LAST)
                div_next = div_reg + 1'b1;
            else
                div_next = '0;
        end
        conv_next = fire;
        adj_next  = conv_done_in && busy_reg;
        val_next  = adj_next ? adj_sum : val_reg;
        busy_next = fire || (busy_reg && !conv_done_in);
    end

    always_ff @(posedge mclk_in)
    begin
        if (rst_in)
        begin
            div_reg  <= '0;
            busy_reg <= 1'b0;
            conv_reg <= 1'b0;
            adj_reg  <= 1'b0;
            val_reg  <= '0;
        end
        else
        begin
            div_reg  <= div_next;
            busy_reg <= busy_next;
            conv_reg <= conv_next;
            adj_reg  <= adj_next;
            val_reg  <= val_next;
        end
    end

    assign conv_start_out = conv_reg;
    assign adj_strobe_out = adj_reg;
    assign adj_value_out  = val_reg;

    // ========================================================
    // checks
    // ========================================================
    AST_PF_DRIVE: assert property (@(posedge mclk_in) disable iff (rst_in)
        (!vcc_ok_s && !on_backup_next) |=> !rst_pin_oe_n_out)
        else $error("reset not driven during power fail");
    AST_RECOV_ENTER: assert property (@(posedge mclk_in) disable iff (rst_in)
        (state_reg == ST_PFAIL && vcc_ok_s && osc_s)
        |=> state_reg == ST_RECOV && !rst_pin_oe_n_out)
        else $error("recovery hold not entered");
    AST_RECOV_HOLD: assert property (@(posedge mclk_in) disable iff (rst_in)
        (state_reg == ST_RECOV && cnt_reg != REC_LAST && vcc_ok_s)
        |=> state_reg == ST_RECOV)
        else $error("recovery hold ended early");
    AST_OSC_BYPASS: assert property (@(posedge mclk_in) disable iff (rst_in)
        (state_reg == ST_PFAIL && vcc_ok_s && !osc_s)
        |=> state_reg == ST_IDLE)
        else $error("recovery not bypassed");
    AST_PB_EDGE: assert property (@(posedge mclk_in) disable iff (rst_in)
        (state_reg == ST_IDLE && pin_fall && vcc_ok_s)
        |=> state_reg == ST_DEBOUNCE)
        else $error("pushbutton edge missed");
    AST_BACKUP_OFF: assert property (@(posedge mclk_in) disable iff (rst_in)
        (!vcc_ok_s && !above_bat_s)
        |=> on_backup_out && rst_pin_oe_n_out)
        else $error("reset driven on backup");
    AST_SEL_MAIN: assert property (@(posedge mclk_in) disable iff (rst_in)
        (vcc_ok_s || above_bat_s) |=> !on_backup_out)
        else $error("backup chosen with main usable");
    AST_CONV_MAIN: assert property (@(posedge mclk_in) disable iff (rst_in)
        (tick_1hz_in && !on_backup_out) |=> conv_start_out)
        else $error("conversion missing on main");
    AST_CONV_BACK: assert property (@(posedge mclk_in) disable iff (rst_in)
        (tick_1hz_in && on_backup_out && div_reg != BACKUP_DIV_LAST)
        |=> !conv_start_out)
        else $error("conversion too often on backup");
    AST_ADJ_SUM: assert property (@(posedge mclk_in) disable iff (rst_in)
        (conv_done_in && busy_reg)
        |=> adj_strobe_out && adj_value_out == $past(adj_sum))
        else $error("adjustment value wrong");

endmodule : smrts_top

// *** tb/smrts_rst_partner.sv ***
// Purpose: host reset input and pushbutton on the open-drain wire
// Assumes: pullup lives on the main supply only
// Notes:   press length is commanded by the bench
module smrts_rst_partner (
    // device side of the pin
    input  wire logic pin_data_in,
    input  wire logic pin_oe_n_in,
    // bench commands
    input  wire logic press_in,
    input  wire logic pullup_live_in,
    // resolved wire level
    output logic      wire_out
);
    timeunit 1ns;
    timeprecision 1ps;

    // ========================================================
    // wire resolution
    // ========================================================
    always_comb
    begin
        if (!pin_oe_n_in && !pin_data_in)
            wire_out = 1'b0;
        else if (press_in)
            wire_out = 1'b0;
        else
            wire_out = pullup_live_in;
    end
endmodule : smrts_rst_partner

// *** tb/tb.sv ***
// Purpose: self-checking bench for the supply monitor and scheduler
// Assumes: short recovery and debounce counts
// Notes:   inputs change on the falling edge
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import smrts_pkg::*;

    localparam int unsigned REC = 20;
    localparam int unsigned DEB = 10;

    // ========================================================
    // signals
    // ========================================================
    logic                  mclk_in = 1'b0;
    logic                  rst_in;
    logic                  vcc_pf, vcc_bat, osc, press, wire_lvl;
    logic                  pin_out, oe_n, tick, done;
    logic signed [9:0]     temp;
    logic signed [7:0]     trim, aging;
    logic                  on_backup, conv_start, adj_strobe;
    logic signed [10:0]    adj_value;
    int                    n_errors = 0;
    int                    samples_checked = 0;

    always #4 mclk_in = ~mclk_in;

    smrts_top #(.RECOVERY_CYC(REC), .DEBOUNCE_CYC(DEB)) i_dut (
        .mclk_in(mclk_in), .rst_in(rst_in),
        .vcc_above_pf_in(vcc_pf), .vcc_above_bat_in(vcc_bat),
        .osc_running_in(osc), .rst_pin_in(wire_lvl),
        .rst_pin_out(pin_out), .rst_pin_oe_n_out(oe_n),
        .tick_1hz_in(tick), .conv_done_in(done), .temp_in(temp),
        .factory_trim_in(trim), .aging_offset_in(aging),
        .on_backup_out(on_backup), .conv_start_out(conv_start),
        .adj_strobe_out(adj_strobe), .adj_value_out(adj_value)
    );

    smrts_rst_partner i_partner (
        .pin_data_in(pin_out), .pin_oe_n_in(oe_n),
        .press_in(press), .pullup_live_in(vcc_pf | vcc_bat),
        .wire_out(wire_lvl)
    );

    // ========================================================
    // helpers
    // ========================================================
    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : conclude

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("wrong value %s expected %0h seen %0h", what, exp, got);
        end
    endtask : chk

    task automatic wait_oe(input logic v, input int lim, output int n);
        n = 0;
        do
        begin
            @(negedge mclk_in);
            n++;
        end
        while (oe_n !== v && n < lim);
        if (oe_n !== v)
        begin
            n_errors++;
            $display("wrong value oe_n wait expected %0b seen timeout", v);
            conclude();
        end
    endtask : wait_oe

    task automatic pulse_tick(output logic started);
        tick = 1'b1;
        @(negedge mclk_in);
        tick = 1'b0;
        started = conv_start;
        @(negedge mclk_in);
    endtask : pulse_tick

    function automatic logic signed [10:0] exp_adj(
        input logic signed [9:0] tp, input logic signed [7:0] ft,
        input logic signed [7:0] ag);
        logic signed [10:0] d;
        d = tp;
        d = (d - 11'sh064) >>> 2;
        return -d + ft + ag;
    endfunction : exp_adj

    task automatic convert(input logic signed [9:0] tp,
                           input logic signed [7:0] ag);
        temp = tp;
        aging = ag;
        done = 1'b1;
        @(negedge mclk_in);
        done = 1'b0;
        chk("adj_strobe", 1, adj_strobe);
        chk("adj_value", exp_adj(tp, trim, ag), adj_value);
        @(negedge mclk_in);
    endtask : convert

    // ========================================================
    // scenarios
    // ========================================================
    task automatic t_power_up();
        int n;
        vcc_pf = 1'b1;
        wait_oe(1'b1, 100, n);
        chk("recovery cycles", REC + 3, n);
        chk("wire released", 1, wire_lvl);
        $display("test power_up done");
    endtask : t_power_up

    task automatic t_sched_main();
        logic signed [9:0] tps [4] = '{10'h064, 10'h0C8, 10'h3D8, 10'h003};
        logic signed [7:0] ags [4] = '{8'h00, 8'hFD, 8'h7F, 8'h80};
        logic s;
        for (int i = 0; i < 4; i++)
        begin
            pulse_tick(s);
            chk("conv_start main", 1, s);
            convert(tps[i], ags[i]);
        end
        done = 1'b1;
        @(negedge mclk_in);
        done = 1'b0;
        chk("adj_strobe unpaired", 0, adj_strobe);
        $display("test sched_main done");
    endtask : t_sched_main

    task automatic t_pushbutton();
        int n;
        press = 1'b1;
        wait_oe(1'b0, 10, n);
        chk("debounce start", 1, n <= 4);
        wait_oe(1'b1, 50, n);
        chk("debounce cycles", DEB, n);
        repeat (15) @(negedge mclk_in);
        chk("wait release oe_n", 1, oe_n);
        chk("wire held", 0, wire_lvl);
        press = 1'b0;
        wait_oe(1'b0, 10, n);
        wait_oe(1'b1, 100, n);
        chk("release hold cycles", REC, n);
        $display("test pushbutton done");
    endtask : t_pushbutton

    task automatic t_short_press();
        int n;
        repeat (4) @(negedge mclk_in);
        press = 1'b1;
        repeat (2) @(negedge mclk_in);
        press = 1'b0;
        wait_oe(1'b0, 10, n);
        wait_oe(1'b1, 50, n);
        chk("short debounce cycles", DEB, n);
        wait_oe(1'b0, 10, n);
        chk("short release seen", 1, n <= 4);
        wait_oe(1'b1, 100, n);
        chk("short hold cycles", REC, n);
        $display("test short_press done");
    endtask : t_short_press

    task automatic t_power_fail();
        int n;
        logic s;
        vcc_pf = 1'b0;
        wait_oe(1'b0, 10, n);
        chk("fail assert", 3, n);
        chk("on_backup main", 0, on_backup);
        pulse_tick(s);
        chk("conv_start below pf", 1, s);
        convert(10'h050, 8'h01);
        vcc_bat = 1'b0;
        repeat (4) @(negedge mclk_in);
        chk("on_backup", 1, on_backup);
        chk("oe_n backup", 1, oe_n);
        chk("wire backup", 0, wire_lvl);
        for (int i = 0; i < 20; i++)
        begin
            pulse_tick(s);
            chk("conv_start backup", i == 9 || i == 19, s);
            if (s)
                convert(10'h1F4, 8'hF0);
        end
        $display("test power_fail done");
    endtask : t_power_fail

    task automatic t_no_osc();
        int n;
        vcc_bat = 1'b1;
        wait_oe(1'b0, 10, n);
        chk("on_backup off", 0, on_backup);
        osc = 1'b0;
        repeat (4) @(negedge mclk_in);
        vcc_pf = 1'b1;
        wait_oe(1'b1, 20, n);
        chk("recovery bypass", 1, n <= 4);
        $display("test no_osc done");
    endtask : t_no_osc

    // ========================================================
    // main sequence
    // ========================================================
    initial
    begin
        rst_in = 1'b1;
        vcc_pf = 1'b0;
        vcc_bat = 1'b1;
        osc = 1'b1;
        press = 1'b0;
        tick = 1'b0;
        done = 1'b0;
        temp = 10'h000;
        trim = 8'hF6;
        aging = 8'h00;
        repeat (5) @(negedge mclk_in);
        rst_in = 1'b0;
        for (int i = 0; i < 4; i++)
        begin
            @(negedge mclk_in);
            chk("oe_n after reset", 0, oe_n);
        end
        t_power_up();
        t_sched_main();
        t_pushbutton();
        t_short_press();
        t_power_fail();
        t_no_osc();
        conclude();
    end
endmodule : tb
